// file: cpu_status_second_pkg.sv
package cpu_status_second_pkg;

    // =========================================
    // register map
    localparam logic [3:0] ADDR_STATUS_SECOND = 4'h0;
    localparam int STATUS_W = 16;

    // =========================================
    // field positions
    localparam int POS_BUFFER_HI = 15;
    localparam int POS_BUFFER_LO = 13;
    localparam int POS_MAP_SELECT = 12;
    localparam int POS_TEST_FLAG = 11;
    localparam int POS_SIGN_EXT = 10;
    localparam int POS_CARRY = 9;
    localparam int POS_HOLD = 6;
    localparam int POS_EXT_FLAG = 4;
    localparam int POS_PSHIFT_HI = 1;
    localparam int POS_PSHIFT_LO = 0;
    localparam logic [15:0] CONST_ONES_MASK = 16'h01AC;

    // =========================================
    // values after reset
    localparam logic [2:0] RST_BUFFER = 3'h0;
    localparam logic [2:0] RST_POINTER = 3'h0;
    localparam logic RST_MAP_SELECT = 1'h0;
    localparam logic RST_TEST_FLAG = 1'h0;
    localparam logic RST_SIGN_EXT = 1'h1;
    localparam logic RST_CARRY = 1'h1;
    localparam logic RST_HOLD = 1'h1;
    localparam logic RST_EXT_FLAG = 1'h1;
    localparam logic [1:0] RST_PSHIFT = 2'h0;

    // =========================================
    // control bits named by set/clear instructions
    typedef enum logic [1:0] {
        sel_none,
        sel_map,
        sel_test
    } ctl_sel_type;

endpackage : cpu_status_second_pkg

// file: test_outcome_unit.sv
`timescale 1ns/100ps

module test_outcome_unit #(
    parameter int N_SRC = 4
) (
    // one entry per test source: valid and the outcome it yields
    input wire logic [N_SRC-1:0] src_valid,
    input wire logic [N_SRC-1:0] src_outcome,
    // merged result
    output logic hit,
    output logic value
);

    logic [N_SRC-1:0] gated;

    // =========================================
    // merge; only one test instruction executes per cycle
    genvar gi;
    generate
        for (gi = 0; gi < N_SRC; gi++) begin : g_src
            assign gated[gi] = src_valid[gi] & src_outcome[gi];
        end
    endgenerate

    assign hit = |src_valid;
    assign value = |gated;

endmodule : test_outcome_unit

// file: cpu_status_register_one.sv
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/100ps

module cpu_status_register_one #(
    parameter int ADDR_W = 4
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // pointer loads
    input wire logic pointer_load,
    input wire logic [2:0] pointer_load_value,
    input wire logic pointer_load_first_restore,
    // second restore instruction
    input wire logic restore_second_valid,
    input wire logic [15:0] restore_second_data,
    // set / clear control bit instructions
    input wire logic set_control_bit_instr,
    input wire logic clear_control_bit_instr,
    input wire cpu_status_second_pkg::ctl_sel_type ctl_sel,
    // test instruction outcomes
    input wire logic logic_test_valid,
    input wire logic logic_result_nonzero,
    input wire logic bit_test_valid,
    input wire logic bit_tested_value,
    input wire logic compare_valid,
    input wire logic compare_true,
    input wire logic normalize_valid,
    input wire logic normalize_xor,
    // conditional branch, call, return
    input wire logic cond_valid,
    input wire logic cond_want_set,
    output logic cond_taken,
    // block zero access decode
    input wire logic block0_access,
    output logic block0_data_sel,
    output logic block0_prog_sel,
    // field outputs
    output logic [2:0] aux_pointer_current,
    output logic [2:0] prev_pointer_buffer,
    output logic ram_block_map_select,
    output logic test_outcome_flag,
    output logic sign_extend_mode,
    output logic carry_flag,
    output logic hold_mode_flag,
    output logic external_flag_output,
    output logic [1:0] product_shift_field
);

    // =========================================
    // state
    logic [2:0] ptr_r, ptr_nxt;
    logic [2:0] buf_r, buf_nxt;
    logic map_r, map_nxt;
    logic tc_r, tc_nxt;
    logic sxm_r, sxm_nxt;
    logic c_r, c_nxt;
    logic hm_r, hm_nxt;
    logic xf_r, xf_nxt;
    logic [1:0] pm_r, pm_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic taken_r, taken_nxt;
    logic dsel_r, dsel_nxt;
    logic psel_r, psel_nxt;

    logic addr_hit;
    logic restore_any;
    logic [15:0] restore_data;
    logic [15:0] status_word;
    logic test_hit;
    logic test_value;

    // =========================================
    // test outcomes, each mapped so that 1 sets the flag
    test_outcome_unit #(
        .N_SRC(4)
    ) u_test (
        .src_valid({normalize_valid, compare_valid, bit_test_valid, logic_test_valid}),
        .src_outcome({normalize_xor, compare_true, bit_tested_value, ~logic_result_nonzero}),
        .hit(test_hit),
        .value(test_value)
    );

    // =========================================
    // restore path: instruction or port write; instruction wins a collision
    assign addr_hit = (reg_addr == ADDR_W'(cpu_status_second_pkg::ADDR_STATUS_SECOND));
    assign restore_any = restore_second_valid | (reg_wr & addr_hit);
    assign restore_data = restore_second_valid ? restore_second_data : reg_wdata;

    // constant positions forced to one whatever was written
    always_comb begin
        status_word = cpu_status_second_pkg::CONST_ONES_MASK;
        status_word[cpu_status_second_pkg::POS_BUFFER_HI:cpu_status_second_pkg::POS_BUFFER_LO] = buf_r;
        status_word[cpu_status_second_pkg::POS_MAP_SELECT] = map_r;
        status_word[cpu_status_second_pkg::POS_TEST_FLAG] = tc_r;
        status_word[cpu_status_second_pkg::POS_SIGN_EXT] = sxm_r;
        status_word[cpu_status_second_pkg::POS_CARRY] = c_r;
        status_word[cpu_status_second_pkg::POS_HOLD] = hm_r;
        status_word[cpu_status_second_pkg::POS_EXT_FLAG] = xf_r;
        status_word[cpu_status_second_pkg::POS_PSHIFT_HI:cpu_status_second_pkg::POS_PSHIFT_LO] = pm_r;
    end

    // =========================================
    // next values
    always_comb begin
        ptr_nxt = ptr_r;
        buf_nxt = buf_r;
        map_nxt = map_r;
        tc_nxt = tc_r;
        sxm_nxt = sxm_r;
        c_nxt = c_r;
        hm_nxt = hm_r;
        xf_nxt = xf_r;
        pm_nxt = pm_r;
        // pointer and buffer; second restore overrides a plain load
        if (restore_any) begin
            buf_nxt = restore_data[cpu_status_second_pkg::POS_BUFFER_HI:cpu_status_second_pkg::POS_BUFFER_LO];
            ptr_nxt = restore_data[cpu_status_second_pkg::POS_BUFFER_HI:cpu_status_second_pkg::POS_BUFFER_LO];
        end else if (pointer_load) begin
            ptr_nxt = pointer_load_value;
            if (!pointer_load_first_restore) begin
                buf_nxt = ptr_r;
            end
        end
        // restored fields; constant bits simply dropped
        if (restore_any) begin
            map_nxt = restore_data[cpu_status_second_pkg::POS_MAP_SELECT];
            tc_nxt = restore_data[cpu_status_second_pkg::POS_TEST_FLAG];
            sxm_nxt = restore_data[cpu_status_second_pkg::POS_SIGN_EXT];
            c_nxt = restore_data[cpu_status_second_pkg::POS_CARRY];
            hm_nxt = restore_data[cpu_status_second_pkg::POS_HOLD];
            xf_nxt = restore_data[cpu_status_second_pkg::POS_EXT_FLAG];
            pm_nxt = restore_data[cpu_status_second_pkg::POS_PSHIFT_HI:cpu_status_second_pkg::POS_PSHIFT_LO];
        end
        // set beats clear when both name the same bit
        if (clear_control_bit_instr) begin
            case (ctl_sel)
                cpu_status_second_pkg::sel_map: map_nxt = 1'h0;
                cpu_status_second_pkg::sel_test: tc_nxt = 1'h0;
                default: ;
            endcase
        end
        if (set_control_bit_instr) begin
            case (ctl_sel)
                cpu_status_second_pkg::sel_map: map_nxt = 1'h1;
                cpu_status_second_pkg::sel_test: tc_nxt = 1'h1;
                default: ;
            endcase
        end
        // hardware test outcome has the last word in its cycle
        if (test_hit) begin
            tc_nxt = test_value;
        end
    end

    // outputs: read data, branch decision, block zero decode
    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_rd && addr_hit) begin
            rdata_nxt = status_word;
        end
        taken_nxt = cond_valid & (tc_r == cond_want_set);
        dsel_nxt = block0_access & ~map_r;
        psel_nxt = block0_access & map_r;
    end

    // =========================================
    // registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            ptr_r <= cpu_status_second_pkg::RST_POINTER;
            buf_r <= cpu_status_second_pkg::RST_BUFFER;
            map_r <= cpu_status_second_pkg::RST_MAP_SELECT;
            tc_r <= cpu_status_second_pkg::RST_TEST_FLAG;
            sxm_r <= cpu_status_second_pkg::RST_SIGN_EXT;
            c_r <= cpu_status_second_pkg::RST_CARRY;
            hm_r <= cpu_status_second_pkg::RST_HOLD;
            xf_r <= cpu_status_second_pkg::RST_EXT_FLAG;
            pm_r <= cpu_status_second_pkg::RST_PSHIFT;
            rdata_r <= 16'h0000;
            taken_r <= 1'h0;
            dsel_r <= 1'h0;
            psel_r <= 1'h0;
        end else begin
            ptr_r <= ptr_nxt;
            buf_r <= buf_nxt;
            map_r <= map_nxt;
            tc_r <= tc_nxt;
            sxm_r <= sxm_nxt;
            c_r <= c_nxt;
            hm_r <= hm_nxt;
            xf_r <= xf_nxt;
            pm_r <= pm_nxt;
            rdata_r <= rdata_nxt;
            taken_r <= taken_nxt;
            dsel_r <= dsel_nxt;
            psel_r <= psel_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign cond_taken = taken_r;
    assign block0_data_sel = dsel_r;
    assign block0_prog_sel = psel_r;
    assign aux_pointer_current = ptr_r;
    assign prev_pointer_buffer = buf_r;
    assign ram_block_map_select = map_r;
    assign test_outcome_flag = tc_r;
    assign sign_extend_mode = sxm_r;
    assign carry_flag = c_r;
    assign hold_mode_flag = hm_r;
    assign external_flag_output = xf_r;
    assign product_shift_field = pm_r;

    // =========================================
    // assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_plain_load;
        pointer_load && !pointer_load_first_restore && !restore_any;
    endsequence

    sequence s_read_status;
        reg_rd && addr_hit;
    endsequence

    a_buffer_takes_old: assert property (s_plain_load |=> buf_r == $past(ptr_r) && ptr_r == $past(pointer_load_value))
        else $error("buffer did not take old pointer");
    a_first_keeps_buf: assert property (pointer_load && pointer_load_first_restore && !restore_any |=> $stable(buf_r))
        else $error("first restore changed buffer");
    a_restore_copies_ptr: assert property (restore_any |=> ptr_r == buf_r && buf_r == $past(restore_data[15:13]))
        else $error("restore did not copy buffer into pointer");
    a_restore_map_bit: assert property (restore_any && !set_control_bit_instr && !clear_control_bit_instr
                                        |=> map_r == $past(restore_data[12]))
        else $error("restore did not load map bit");
    a_block0_decode: assert property (block0_access |=> block0_data_sel == !$past(map_r) && block0_prog_sel == $past(map_r))
        else $error("block zero decode wrong");
    a_map_after_reset: assert property (@(posedge mclk) $fell(reset) |-> !ram_block_map_select)
        else $error("map bit not zero after reset");
    a_test_event_value: assert property (test_hit |=> tc_r == $past(test_value))
        else $error("test flag missed an outcome");
    a_logic_nonzero_clr: assert property (logic_test_valid && logic_result_nonzero |=> !tc_r)
        else $error("nonzero logic result did not clear flag");
    a_bit_one_sets: assert property (bit_test_valid && bit_tested_value |=> tc_r)
        else $error("tested one bit did not set flag");
    a_clear_test: assert property (clear_control_bit_instr && !set_control_bit_instr && ctl_sel == cpu_status_second_pkg::sel_test
                                   && !test_hit |=> !tc_r)
        else $error("clear instruction left flag set");
    a_set_test: assert property (set_control_bit_instr && ctl_sel == cpu_status_second_pkg::sel_test && !test_hit |=> tc_r)
        else $error("set instruction left flag clear");
    a_cond_uses_flag: assert property (cond_valid |=> cond_taken == ($past(tc_r) == $past(cond_want_set)))
        else $error("conditional decision wrong");
    a_const_bits_one: assert property (s_read_status |=> (reg_rdata & cpu_status_second_pkg::CONST_ONES_MASK)
                                       == cpu_status_second_pkg::CONST_ONES_MASK)
        else $error("constant bits not read as one");
    a_read_one_cycle: assert property (s_read_status ##1 !(reg_rd && addr_hit) |=> reg_rdata == 16'h0000)
        else $error("read data held past its cycle");

endmodule : cpu_status_register_one

// file: tb.sv
`timescale 1ns/100ps

module tb;
    // =========================================
    // clock, stimulus and design
    logic mclk = 1'h0;
    logic reset = 1'h1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'h0, reg_rd = 1'h0;
    logic [15:0] reg_rdata;
    logic pointer_load = 1'h0, pointer_load_first_restore = 1'h0;
    logic [2:0] pointer_load_value = 3'h0;
    logic restore_second_valid = 1'h0;
    logic [15:0] restore_second_data = 16'h0000;
    logic set_control_bit_instr = 1'h0, clear_control_bit_instr = 1'h0;
    cpu_status_second_pkg::ctl_sel_type ctl_sel = cpu_status_second_pkg::sel_none;
    logic logic_test_valid = 1'h0, logic_result_nonzero = 1'h0, bit_test_valid = 1'h0, bit_tested_value = 1'h0;
    logic compare_valid = 1'h0, compare_true = 1'h0, normalize_valid = 1'h0, normalize_xor = 1'h0;
    logic cond_valid = 1'h0, cond_want_set = 1'h0, cond_taken;
    logic block0_access = 1'h0, block0_data_sel, block0_prog_sel;
    logic [2:0] aux_pointer_current, prev_pointer_buffer;
    logic ram_block_map_select, test_outcome_flag, sign_extend_mode, carry_flag;
    logic hold_mode_flag, external_flag_output;
    logic [1:0] product_shift_field;
    int n_errors = 0, total_checks = 0;
    logic [31:0] seed = 32'h00000060;
    // model state, kept as plain integers
    int m_ptr, m_buf, m_map, m_tf, m_sx, m_c, m_hm, m_xf, m_ps, m_rdata, m_ct, m_ds, m_pg;

    always #25 mclk = ~mclk;

    cpu_status_register_one #(.ADDR_W(4)) i_dut (
        .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pointer_load(pointer_load),
        .pointer_load_value(pointer_load_value), .pointer_load_first_restore(pointer_load_first_restore),
        .restore_second_valid(restore_second_valid), .restore_second_data(restore_second_data),
        .set_control_bit_instr(set_control_bit_instr), .clear_control_bit_instr(clear_control_bit_instr),
        .ctl_sel(ctl_sel), .logic_test_valid(logic_test_valid), .logic_result_nonzero(logic_result_nonzero),
        .bit_test_valid(bit_test_valid), .bit_tested_value(bit_tested_value), .compare_valid(compare_valid),
        .compare_true(compare_true), .normalize_valid(normalize_valid), .normalize_xor(normalize_xor),
        .cond_valid(cond_valid), .cond_want_set(cond_want_set), .cond_taken(cond_taken),
        .block0_access(block0_access), .block0_data_sel(block0_data_sel), .block0_prog_sel(block0_prog_sel),
        .aux_pointer_current(aux_pointer_current), .prev_pointer_buffer(prev_pointer_buffer),
        .ram_block_map_select(ram_block_map_select), .test_outcome_flag(test_outcome_flag),
        .sign_extend_mode(sign_extend_mode), .carry_flag(carry_flag), .hold_mode_flag(hold_mode_flag),
        .external_flag_output(external_flag_output), .product_shift_field(product_shift_field)
    );

    // =========================================
    // helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // =========================================
    // reference model, one step per clock edge
    task automatic model_step();
        logic [15:0] d;
        logic [15:0] word;
        int rs;
        word = 16'(m_buf << 13) | 16'(m_map << 12) | 16'(m_tf << 11) | 16'(m_sx << 10) | 16'(m_c << 9)
             | 16'(m_hm << 6) | 16'(m_xf << 4) | 16'(m_ps) | cpu_status_second_pkg::CONST_ONES_MASK;
        if (reset) begin
            {m_ptr, m_buf, m_map, m_tf, m_ps, m_rdata, m_ct, m_ds, m_pg} = '0;
            {m_sx, m_c, m_hm, m_xf} = {32'h00000001, 32'h00000001, 32'h00000001, 32'h00000001};
            return;
        end
        rs = restore_second_valid || (reg_wr && reg_addr == cpu_status_second_pkg::ADDR_STATUS_SECOND);
        d = restore_second_valid ? restore_second_data : reg_wdata;
        m_rdata = (reg_rd && reg_addr == cpu_status_second_pkg::ADDR_STATUS_SECOND) ? int'(word) : 0;
        m_ct = cond_valid && (m_tf == int'(cond_want_set));
        m_ds = block0_access && m_map == 0;
        m_pg = block0_access && m_map == 1;
        if (rs) begin
            m_buf = d[15:13];
            m_ptr = d[15:13];
        end else if (pointer_load) begin
            if (!pointer_load_first_restore) m_buf = m_ptr;
            m_ptr = pointer_load_value;
        end
        if (set_control_bit_instr && ctl_sel == cpu_status_second_pkg::sel_map) m_map = 1;
        else if (clear_control_bit_instr && ctl_sel == cpu_status_second_pkg::sel_map) m_map = 0;
        else if (rs) m_map = d[12];
        if (logic_test_valid) m_tf = !logic_result_nonzero;
        else if (bit_test_valid) m_tf = bit_tested_value;
        else if (compare_valid) m_tf = compare_true;
        else if (normalize_valid) m_tf = normalize_xor;
        else if (set_control_bit_instr && ctl_sel == cpu_status_second_pkg::sel_test) m_tf = 1;
        else if (clear_control_bit_instr && ctl_sel == cpu_status_second_pkg::sel_test) m_tf = 0;
        else if (rs) m_tf = d[11];
        if (rs) begin
            {m_sx, m_c, m_hm, m_xf, m_ps} = {32'(d[10]), 32'(d[9]), 32'(d[6]), 32'(d[4]), 32'(d[1:0])};
        end
    endtask : model_step

    // =========================================
    // watchdog: 4000 cycles expected, twice that allowed
    initial begin
        #400000;
        n_errors++;
        end_of_test();
    end

    // =========================================
    // random traffic, every result compared with the model
    initial begin
        logic [31:0] r, q;
        logic go;
        for (int i = 0; i < 4000; i++) begin
            @(posedge mclk);
            model_step();
            r = xs();
            q = xs();
            go = (i >= 6);
            // reset held for six edges; no request until it is low
            reset <= (i < 5);
            // strobes never together; three quarters of accesses hit an unmapped address
            reg_wr <= go && r[2:0] == 3'h0;
            reg_rd <= go && r[2:0] == 3'h1;
            reg_addr <= {2'h0, r[4:3]};
            reg_wdata <= r[31:16];
            pointer_load <= go && r[5];
            pointer_load_value <= r[8:6];
            pointer_load_first_restore <= r[9];
            restore_second_valid <= go && r[12:10] == 3'h0;
            restore_second_data <= q[15:0];
            set_control_bit_instr <= go && r[13] && r[14];
            clear_control_bit_instr <= go && r[15] && q[16];
            ctl_sel <= cpu_status_second_pkg::ctl_sel_type'(2'(q[31:30] % 2'h3));
            // at most one test source per cycle
            logic_test_valid <= go && q[19:17] == 3'h1;
            bit_test_valid <= go && q[19:17] == 3'h2;
            compare_valid <= go && q[19:17] == 3'h3;
            normalize_valid <= go && q[19:17] == 3'h4;
            {logic_result_nonzero, bit_tested_value, compare_true, normalize_xor} <= q[23:20];
            cond_valid <= go && q[24];
            cond_want_set <= q[25];
            block0_access <= go && q[26];
            #1;
            check(reg_rdata, 16'(m_rdata));
            check(16'(aux_pointer_current), 16'(m_ptr));
            check(16'(prev_pointer_buffer), 16'(m_buf));
            check(16'(ram_block_map_select), 16'(m_map));
            check(16'(test_outcome_flag), 16'(m_tf));
            check(16'(cond_taken), 16'(m_ct));
            check({14'h0000, block0_data_sel, block0_prog_sel}, 16'((m_ds << 1) | m_pg));
            check({10'h000, sign_extend_mode, carry_flag, hold_mode_flag, external_flag_output,
                   product_shift_field}, 16'((m_sx << 5) | (m_c << 4) | (m_hm << 3) | (m_xf << 2) | m_ps));
        end
        end_of_test();
    end
endmodule : tb
